// ==== core/aie_cfg.svh ====
// Constants for the alarm indication encoder
// How it works
// - Fast 4 Hz blink for calibration-needed codes
// - Slow 1 Hz blink for codes 111 to 116
// - Steady LED for start-blocking fault codes
// - Relay off in blink, on with start/fault
// - Polarity option inverts every relay state
// - Fault flag on error, caution on warning until start
// - Error code in third word bits 0-9
// - Fault drives error level, thirteen levels
// - Codes 101/102/103 give 0.66/1.33/2.00 V
// - Codes 107, 108, 307-310 give 2.66 V
// - Codes 201 to 203 give 3.33 V
// - Codes 304 and 305 give 4.00 V
// - Codes 901, 913-918 give 4.66 V
// - Warnings toggle level and 10 V at 1 Hz
// - Start during warning holds level steady
// - Faults: steady level, LED on, relay on
// - Clear by request bit or supply dropout
// - Request bit clears only when released
// - Three-digit codes kept and reported
// - Supply low: standby, 0 V, standby flag
`ifndef AIE_CFG_SVH
`define AIE_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AIE_OFF_CTRL 8'h00
`define AIE_OFF_STAT 8'h04
`define AIE_OFF_ERRW 8'h08
`define AIE_OFF_AOUT 8'h0C

// ----------------------------------------
// Control fields and reset value
// ----------------------------------------
`define AIE_CTRL_INV 0
`define AIE_CTRL_START 1
`define AIE_CTRL_CLR 2
`define AIE_CTRL_RST 3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define AIE_CLK_HZ 100000000
`define AIE_FAST_HALF_MS 125
`define AIE_FAST_HALF_CYC (`AIE_CLK_HZ / 1000 * `AIE_FAST_HALF_MS)

// ----------------------------------------
// Output levels in millivolts
// ----------------------------------------
`define AIE_MV_0V66 14'h0294
`define AIE_MV_1V33 14'h0532
`define AIE_MV_2V00 14'h07D0
`define AIE_MV_2V66 14'h0A64
`define AIE_MV_3V33 14'h0D02
`define AIE_MV_4V00 14'h0FA0
`define AIE_MV_4V66 14'h1234
`define AIE_MV_5V33 14'h14D2
`define AIE_MV_6V00 14'h1770
`define AIE_MV_6V66 14'h1A04
`define AIE_MV_7V33 14'h1CA2
`define AIE_MV_8V00 14'h1F40
`define AIE_MV_8V66 14'h21D4
`define AIE_MV_FULL 14'h2710

`endif

// ==== core/aie_pkg.sv ====
// Types of the alarm indication encoder
package aie_pkg;
  typedef enum logic [3:0] {
    AIE_IDLE = 4'b0001,
    AIE_FAST = 4'b0010,
    AIE_SLOW = 4'b0100,
    AIE_FAULT = 4'b1000
  } aie_state_e;

  typedef logic [13:0] aie_mv_t;

  typedef struct packed {
    aie_state_e cls;
    aie_mv_t lvl;
  } aie_dec_s;

  typedef struct packed {
    logic [12:0] rsvd;
    logic standby;
    logic caution;
    logic fault;
  } aie_stat_s;
endpackage

// ==== core/aie_top.sv ====
// Alarm indication encoder with AXI4-Lite register access
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`include "aie_cfg.svh"

module aie_top #(
  parameter int unsigned FAST_HALF_CYC = `AIE_FAST_HALF_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic err_valid,
  input wire logic [9:0] err_code,
  input wire logic [13:0] temp_mv,
  input wire logic supply_low,
  output logic alarm_led,
  output logic alarm_relay,
  output logic [13:0] aout_mv,
  output aie_pkg::aie_stat_s status_word,
  output logic [15:0] error_word
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [2:0] ctrl_reg;
  logic clr_prev_reg;
  logic sup_meta_reg;
  logic sup_sync_reg;
  logic standby_reg;
  logic [23:0] div_reg;
  logic [2:0] phase_reg;
  aie_pkg::aie_state_e st_reg;
  logic [9:0] code_reg;
  aie_pkg::aie_mv_t lvl_reg;
  logic esc_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic aw_got_next;
  logic w_got_next;
  logic bvalid_next;
  logic rvalid_next;
  logic tick;
  logic clr_evt;
  logic warn;
  logic relay_def;
  logic led_next;
  aie_pkg::aie_mv_t aout_next;
  aie_pkg::aie_dec_s dec;

  // ----------------------------------------
  // Assertion clocking
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // Code decoder
  // ----------------------------------------
  function automatic aie_pkg::aie_dec_s decode(input logic [9:0] c);
    aie_pkg::aie_dec_s d;
    d.cls = aie_pkg::AIE_FAULT;
    d.lvl = `AIE_MV_4V66;
    case (c)
      10'h065: d.lvl = `AIE_MV_0V66;
      10'h066: d.lvl = `AIE_MV_1V33;
      10'h067: d.lvl = `AIE_MV_2V00;
      10'h06B, 10'h06C, 10'h133, 10'h134, 10'h135, 10'h136: begin
        d.lvl = `AIE_MV_2V66;
      end
      10'h0C9, 10'h0CA, 10'h0CB: d.lvl = `AIE_MV_3V33;
      10'h130, 10'h131: d.lvl = `AIE_MV_4V00;
      10'h068, 10'h069, 10'h06A, 10'h12E, 10'h12F: begin
        d.cls = aie_pkg::AIE_FAST;
        d.lvl = `AIE_MV_5V33;
      end
      10'h0D3: begin
        d.cls = aie_pkg::AIE_FAST;
        d.lvl = `AIE_MV_6V00;
      end
      10'h06F: begin
        d.cls = aie_pkg::AIE_SLOW;
        d.lvl = `AIE_MV_6V66;
      end
      10'h070: begin
        d.cls = aie_pkg::AIE_SLOW;
        d.lvl = `AIE_MV_7V33;
      end
      10'h071, 10'h072: begin
        d.cls = aie_pkg::AIE_SLOW;
        d.lvl = `AIE_MV_8V00;
      end
      10'h073, 10'h074: begin
        d.cls = aie_pkg::AIE_SLOW;
        d.lvl = `AIE_MV_8V66;
      end
      default: d.lvl = `AIE_MV_4V66;
    endcase
    return d;
  endfunction

  assign dec = decode(err_code);

  // ----------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------
  assign aw_fire = s_awvalid & s_awready;
  assign w_fire = s_wvalid & s_wready;
  assign ar_fire = s_arvalid & s_arready;
  assign do_write = (aw_got_reg | aw_fire) & (w_got_reg | w_fire) & ~s_bvalid;
  assign wr_addr = aw_fire ? s_awaddr : aw_addr_reg;
  assign wr_data = w_fire ? s_wdata : w_data_reg;
  assign wr_strb = w_fire ? s_wstrb : w_strb_reg;
  assign aw_got_next = (aw_got_reg | aw_fire) & ~do_write;
  assign w_got_next = (w_got_reg | w_fire) & ~do_write;
  assign bvalid_next = do_write | (s_bvalid & ~s_bready);
  assign rvalid_next = ar_fire | (s_rvalid & ~s_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      if (aw_fire) begin
        aw_addr_reg <= s_awaddr;
      end
      if (w_fire) begin
        w_data_reg <= s_wdata;
        w_strb_reg <= s_wstrb;
      end
      s_awready <= ~aw_got_next & ~bvalid_next;
      s_wready <= ~w_got_next & ~bvalid_next;
      s_bvalid <= bvalid_next;
      if (do_write) begin
        s_bresp <= (wr_addr[7:4] == 4'h0 && wr_addr[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= 2'h0;
    end else begin
      s_arready <= ~rvalid_next;
      s_rvalid <= rvalid_next;
      if (ar_fire) begin
        s_rresp <= 2'h0;
        case (s_araddr)
          `AIE_OFF_CTRL: s_rdata <= {29'h0, ctrl_reg};
          `AIE_OFF_STAT: s_rdata <= {12'h000, st_reg, status_word};
          `AIE_OFF_ERRW: s_rdata <= {16'h0000, error_word};
          `AIE_OFF_AOUT: s_rdata <= {18'h00000, aout_mv};
          default: begin
            s_rdata <= 32'h0000_0000;
            s_rresp <= 2'h2;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `AIE_CTRL_RST;
    end else if (do_write && wr_addr == `AIE_OFF_CTRL && wr_strb[0]) begin
      ctrl_reg <= wr_data[2:0];
    end
  end

  // ----------------------------------------
  // Supply sense and clear events
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sup_meta_reg <= 1'b0;
      sup_sync_reg <= 1'b0;
      standby_reg <= 1'b0;
      clr_prev_reg <= 1'b0;
    end else begin
      sup_meta_reg <= supply_low;
      sup_sync_reg <= sup_meta_reg;
      standby_reg <= sup_sync_reg;
      clr_prev_reg <= ctrl_reg[`AIE_CTRL_CLR];
    end
  end

  // Request bit acts on release; supply return acts too
  assign clr_evt = (clr_prev_reg & ~ctrl_reg[`AIE_CTRL_CLR])
                 | (standby_reg & ~sup_sync_reg);

  // ----------------------------------------
  // Blink divider
  // ----------------------------------------
  assign tick = (div_reg == 24'(FAST_HALF_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 24'h000000;
      phase_reg <= 3'h0;
    end else if (tick) begin
      div_reg <= 24'h000000;
      phase_reg <= phase_reg + 3'h1;
    end else begin
      div_reg <= div_reg + 24'h000001;
    end
  end

  // ----------------------------------------
  // Error latch
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= aie_pkg::AIE_IDLE;
      code_reg <= 10'h000;
      lvl_reg <= 14'h0000;
    end else if (err_valid && (st_reg == aie_pkg::AIE_IDLE || clr_evt)) begin
      st_reg <= dec.cls;
      code_reg <= err_code;
      lvl_reg <= dec.lvl;
    end else if (clr_evt) begin
      st_reg <= aie_pkg::AIE_IDLE;
      code_reg <= 10'h000;
    end
  end

  clear_rel_a: assert property (
    ($fell(ctrl_reg[`AIE_CTRL_CLR]) && !err_valid) |=> st_reg == aie_pkg::AIE_IDLE)
    else $error("Release of clear request ignored");
  hold_code_a: assert property (
    (st_reg != aie_pkg::AIE_IDLE && !clr_evt) |=> $stable(code_reg) && st_reg != aie_pkg::AIE_IDLE)
    else $error("Latched error changed");

  assign warn = (st_reg == aie_pkg::AIE_FAST) || (st_reg == aie_pkg::AIE_SLOW);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      esc_reg <= 1'b0;
    end else if (clr_evt || st_reg == aie_pkg::AIE_IDLE) begin
      esc_reg <= 1'b0;
    end else if (warn && ctrl_reg[`AIE_CTRL_START]) begin
      esc_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Indication mapping
  // ----------------------------------------
  always_comb begin
    led_next = 1'b0;
    relay_def = 1'b0;
    aout_next = temp_mv;
    case (st_reg)
      aie_pkg::AIE_IDLE: begin
        aout_next = temp_mv;
      end
      aie_pkg::AIE_FAST: begin
        led_next = esc_reg | phase_reg[0];
        relay_def = esc_reg;
        aout_next = (esc_reg || phase_reg[2]) ? lvl_reg : `AIE_MV_FULL;
      end
      aie_pkg::AIE_SLOW: begin
        led_next = esc_reg | phase_reg[2];
        relay_def = esc_reg;
        aout_next = (esc_reg || phase_reg[2]) ? lvl_reg : `AIE_MV_FULL;
      end
      aie_pkg::AIE_FAULT: begin
        led_next = 1'b1;
        relay_def = 1'b1;
        aout_next = lvl_reg;
      end
      default: begin
        led_next = 1'b0;
      end
    endcase
    if (standby_reg) begin
      aout_next = 14'h0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_led <= 1'b0;
      alarm_relay <= 1'b0;
      aout_mv <= 14'h0000;
    end else begin
      alarm_led <= led_next;
      alarm_relay <= relay_def ^ ctrl_reg[`AIE_CTRL_INV];
      aout_mv <= aout_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_word <= '0;
      error_word <= 16'h0000;
    end else begin
      status_word.fault <= (st_reg != aie_pkg::AIE_IDLE);
      status_word.caution <= warn & ~esc_reg;
      status_word.standby <= standby_reg;
      status_word.rsvd <= 13'h0000;
      error_word <= {6'h00, code_reg};
    end
  end

  // ----------------------------------------
  // Indication and status checks
  // ----------------------------------------
  fault_led_a: assert property (
    st_reg == aie_pkg::AIE_FAULT |=> alarm_led)
    else $error("Alarm LED not steady in fault");
  fast_led_a: assert property (
    (st_reg == aie_pkg::AIE_FAST && !esc_reg) |=> alarm_led == $past(phase_reg[0]))
    else $error("Fast blink wrong");
  slow_led_a: assert property (
    (st_reg == aie_pkg::AIE_SLOW && !esc_reg) |=> alarm_led == $past(phase_reg[2]))
    else $error("Slow blink wrong");
  relay_fault_a: assert property (
    st_reg == aie_pkg::AIE_FAULT |=> alarm_relay != $past(ctrl_reg[`AIE_CTRL_INV]))
    else $error("Relay wrong in fault");
  relay_warn_a: assert property (
    (warn && !esc_reg) |=> alarm_relay == $past(ctrl_reg[`AIE_CTRL_INV]))
    else $error("Relay wrong in warning");
  fault_flag_a: assert property (
    st_reg != aie_pkg::AIE_IDLE |=> status_word.fault)
    else $error("Fault flag missing");
  code_word_a: assert property (
    (err_valid && st_reg == aie_pkg::AIE_IDLE) |-> ##2 error_word[9:0] == $past(err_code, 2))
    else $error("Error code not reported");
  standby_out_a: assert property (
    (sup_sync_reg && $past(sup_sync_reg)) |-> ##1 aout_mv == 14'h0000)
    else $error("Standby output not zero");
  hold_level_a: assert property (
    (esc_reg && warn && !standby_reg) |=> aout_mv == $past(lvl_reg))
    else $error("Escalated warning still toggling");

endmodule

// ==== sim/aie_ctrl_model.sv ====
// Machine controller model: AXI4-Lite master for the register bus
`include "aie_cfg.svh"

module aie_ctrl_model (
  input wire logic aclk,
  output logic [7:0] s_awaddr,
  output logic s_awvalid,
  input wire logic s_awready,
  output logic [31:0] s_wdata,
  output logic [3:0] s_wstrb,
  output logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  output logic s_bready,
  output logic [7:0] s_araddr,
  output logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  output logic s_rready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
    {s_araddr, s_arvalid, s_rready} = '0;
  end

  // ----
  // Bus cycles
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) begin
        s_awvalid <= 1'b0;
        s_awaddr <= ~a;
      end
      if (s_wvalid && s_wready) begin
        s_wvalid <= 1'b0;
        s_wdata <= ~d;
      end
      if (s_bvalid === 1'b1) begin
        r = s_bresp;
        s_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_arvalid && s_arready) begin
        s_arvalid <= 1'b0;
        s_araddr <= ~a;
      end
      if (s_rvalid === 1'b1) begin
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // Level index read back with a window one step wide around each level
  function automatic int level_of(input logic [13:0] mv);
    return (int'(mv) * 3 + 1000) / 2000;
  endfunction

  // Clear request is a pulse: set, then released
  task automatic clear_fault(input logic [31:0] base);
    logic [1:0] r;
    wr(`AIE_OFF_CTRL, base | 32'h4, r);
    wr(`AIE_OFF_CTRL, base, r);
  endtask
endmodule

// ==== sim/alarm_indication_encoder_tb_top.sv ====
// Self-checking testbench of the alarm indication encoder
`include "aie_cfg.svh"

module alarm_indication_encoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [9:0] LO [17] = '{10'h065, 10'h066, 10'h067, 10'h06B, 10'h133, 10'h0C9,
    10'h130, 10'h385, 10'h391, 10'h3B6, 10'h068, 10'h12E, 10'h0D3, 10'h06F, 10'h070,
    10'h071, 10'h073};
  localparam logic [9:0] HI [17] = '{10'h065, 10'h066, 10'h067, 10'h06C, 10'h136, 10'h0CB,
    10'h131, 10'h385, 10'h396, 10'h3B6, 10'h06A, 10'h12F, 10'h0D3, 10'h06F, 10'h070,
    10'h072, 10'h074};
  localparam logic [13:0] LV [17] = '{`AIE_MV_0V66, `AIE_MV_1V33, `AIE_MV_2V00,
    `AIE_MV_2V66, `AIE_MV_2V66, `AIE_MV_3V33, `AIE_MV_4V00, `AIE_MV_4V66, `AIE_MV_4V66,
    `AIE_MV_4V66, `AIE_MV_5V33, `AIE_MV_5V33, `AIE_MV_6V00, `AIE_MV_6V66, `AIE_MV_7V33,
    `AIE_MV_8V00, `AIE_MV_8V66};
  localparam int HF [17] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8, 8, 8, 32, 32, 32, 32};
  localparam int LI [17] = '{1, 2, 3, 4, 4, 5, 6, 7, 7, 7, 8, 8, 9, 10, 11, 12, 13};

  logic aclk, aresetn, err_valid, supply_low, alarm_led, alarm_relay;
  logic [9:0] err_code;
  logic [13:0] temp_mv, aout_mv;
  aie_pkg::aie_stat_s status_word;
  logic [15:0] error_word;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, d;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, r;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  int error_cnt, checked, cyc;

  aie_top #(.FAST_HALF_CYC(8)) aie_top_inst (.aclk, .aresetn, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .err_valid, .err_code, .temp_mv, .supply_low, .alarm_led, .alarm_relay, .aout_mv,
    .status_word, .error_word);

  aie_ctrl_model aie_ctrl_model_inst (.aclk, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);

  // ----
  // Clock and timeout
  // ----
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      finish_test();
    end
  end

  // ----
  // Helpers
  // ----
  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report(input logic [9:0] c);
    @(posedge aclk);
    err_valid <= 1'b1;
    err_code <= c;
    @(posedge aclk);
    err_valid <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  function automatic logic cur(input bit sel);
    return sel ? (aout_mv === `AIE_MV_FULL) : alarm_led;
  endfunction

  // Cycles between two changes of the LED or of the output toggle
  task automatic half(input bit sel, input int exp);
    logic v;
    int n;
    for (int k = 0; k < 2; k++) begin
      v = cur(sel);
      n = 0;
      while (cur(sel) === v && n < 200) begin
        @(posedge aclk);
        n++;
      end
    end
    chk(n, exp);
  endtask

  task automatic wait_lvl(input logic [13:0] lv);
    int n;
    n = 0;
    while (aout_mv === `AIE_MV_FULL && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk(aout_mv, lv);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_basic;
    chk({status_word, error_word}, 32'h0);
    chk(aout_mv, temp_mv);
    aie_ctrl_model_inst.rd(`AIE_OFF_CTRL, d, r);
    chk({r, d}, 34'h0);
    aie_ctrl_model_inst.rd(8'h10, d, r);
    chk({r, d}, {2'h2, 32'h0});
  endtask

  task automatic t_fault;
    report(10'h065);
    aie_ctrl_model_inst.rd(`AIE_OFF_ERRW, d, r);
    chk(d, 32'h0065);
    report(10'h066);
    chk(error_word, 16'h0065);
    aie_ctrl_model_inst.wr(`AIE_OFF_STAT, 32'hFFFF, r);
    chk({r, status_word}, 18'h00001);
    aie_ctrl_model_inst.wr(`AIE_OFF_CTRL, 32'h4, r);
    repeat (6) @(posedge aclk);
    chk(error_word, 16'h0065);
    aie_ctrl_model_inst.wr(`AIE_OFF_CTRL, 32'h0, r);
    repeat (4) @(posedge aclk);
    chk({status_word, error_word}, 32'h0);
    chk(aout_mv, temp_mv);
  endtask

  task automatic t_codes;
    logic [9:0] c;
    for (int g = 0; g < 17; g++) begin
      for (c = LO[g]; c <= HI[g]; c++) begin
        report(c);
        chk(error_word, {6'h00, c});
        if (HF[g] == 0) begin
          chk(status_word, 16'h0001);
          chk({alarm_led, alarm_relay}, 2'b11);
          chk(aout_mv, LV[g]);
          chk(aie_ctrl_model_inst.level_of(aout_mv), LI[g]);
        end else begin
          chk(status_word, 16'h0003);
          chk(alarm_relay, 1'b0);
          wait_lvl(LV[g]);
          chk(aie_ctrl_model_inst.level_of(aout_mv), LI[g]);
          half(1'b0, HF[g]);
        end
        aie_ctrl_model_inst.clear_fault(32'h0);
        repeat (4) @(posedge aclk);
        chk(error_word, 16'h0);
      end
    end
  endtask

  task automatic t_warn;
    report(10'h068);
    half(1'b1, 32);
    aie_ctrl_model_inst.wr(`AIE_OFF_CTRL, 32'h2, r);
    repeat (4) @(posedge aclk);
    chk(status_word, 16'h0001);
    chk({alarm_led, alarm_relay}, 2'b11);
    repeat (40) @(posedge aclk);
    chk({alarm_led, aout_mv}, {1'b1, `AIE_MV_5V33});
    aie_ctrl_model_inst.clear_fault(32'h0);
  endtask

  task automatic t_pol;
    aie_ctrl_model_inst.wr(`AIE_OFF_CTRL, 32'h1, r);
    report(10'h065);
    chk(alarm_relay, 1'b0);
    aie_ctrl_model_inst.clear_fault(32'h1);
    report(10'h06F);
    chk(alarm_relay, 1'b1);
    aie_ctrl_model_inst.wr(`AIE_OFF_CTRL, 32'h3, r);
    repeat (4) @(posedge aclk);
    chk(alarm_relay, 1'b0);
    aie_ctrl_model_inst.clear_fault(32'h0);
  endtask

  task automatic t_supply;
    report(10'h065);
    supply_low <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({status_word[2], aout_mv}, 15'h4000);
    supply_low <= 1'b0;
    repeat (8) @(posedge aclk);
    chk({status_word, error_word}, 32'h0);
  endtask

  initial begin
    {error_cnt, checked, cyc} = '0;
    {aresetn, err_valid, err_code, supply_low} = '0;
    temp_mv = 14'h0123;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_basic();
    t_fault();
    t_codes();
    t_warn();
    t_pol();
    t_supply();
    finish_test();
  end
endmodule
